// [src/dtws_target.sv]
// Target end: dual-type two-wire slave front end.
// Assumes a master on the interface and a byte store on the user side
// whose read data follows o_addr and o_comp_sel combinationally.
`timescale 1ns/1ps
module dtws_target
  import dtws_pkg::*;
(
  input  wire logic              i_clk_sys,     // System clock
  input  wire logic              i_srst,        // Synchronous reset
  dtws_if.target                 bus,           // Two-wire lines
  input  wire logic [1:0]        i_sel_pins,    // Select straps
  input  wire logic              i_power_fail,  // Supply below trip
  input  wire logic [7:0]        i_rd_data,     // Byte at o_addr
  output logic                   o_wr_stb,      // Write byte pulse
  output logic      [7:0]        o_wr_data,     // Byte to write
  output logic                   o_rd_stb,      // Byte fetched pulse
  output logic      [ADDR_W-1:0] o_addr,        // Current address
  output logic                   o_comp_sel,    // Companion selected
  output logic                   o_busy         // Operation in progress
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [4:0]   pins_s;      // Synchronised pins
  logic         scl_s;       // Clock line
  logic         sda_s;       // Data line
  logic         pf_s;        // Power trip
  logic [1:0]   sel_s;       // Select straps
  logic         scl_p;       // Clock one cycle back
  logic         sda_p;       // Data one cycle back
  dtws_tstate_t state;       // Protocol state
  logic [3:0]   cnt;         // Bits seen in byte
  logic [7:0]   shreg;       // Shift register
  logic         is_read;     // Read transfer
  logic         acked;       // Master acknowledged
  logic [1:0]   abytes;      // Address bytes still due

  dtws_sync #(
    .W (5)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   ({bus.scl, bus.sda, i_power_fail, i_sel_pins}),
    .o_sync    (pins_s)
  );

  assign {scl_s, sda_s, pf_s, sel_s} = pins_s;

  // Previous line levels for edges
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  logic scl_rise;   // Clock went high
  logic scl_fall;   // Clock went low
  logic start_det;  // Start seen
  logic stop_det;   // Stop seen
  logic abort;      // Any abort cause
  logic last_fall;  // Clock fall after eighth bit
  logic dev_hit;    // Address byte names us
  logic addr_ok;    // Companion address in range

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign abort     = pf_s | stop_det;
  assign last_fall = scl_fall & (cnt == BYTE_BITS);

  // Type and select decode
  assign dev_hit = ((shreg[TYPE_HI:TYPE_LO] == DEV_MEM)
                   | (shreg[TYPE_HI:TYPE_LO] == DEV_COMP))
                   & (shreg[SEL_HI:SEL_LO] == sel_s);

  // Range check on companion address byte
  assign addr_ok = !(o_comp_sel && (abytes != 2'h0) && (shreg > COMP_ADDR_MAX));

  // Next address, companion wraps in its byte
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                 input logic comp);
    logic [ADDR_W-1:0] inc;
    inc = a + 15'h1;
    next_addr = comp ? {7'h0, inc[7:0]} : inc;
  endfunction

  // ----------------------------------------------------------------
  // Protocol state, shifter and data line drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state          <= T_IDLE;
      cnt            <= 4'h0;
      shreg          <= 8'h00;
      is_read        <= 1'b0;
      acked          <= 1'b0;
      o_comp_sel     <= 1'b0;
      bus.t_sda_oe_n <= 1'b1;
    end else if (abort) begin
      // Stop or power trip: back to idle, data line released
      state          <= T_IDLE;
      bus.t_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      // New address expected
      state          <= T_ADDR;
      cnt            <= 4'h0;
      bus.t_sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        T_IDLE: begin
          cnt <= 4'h0;
        end
        T_ADDR, T_RX: begin
          if (scl_rise) begin
            // Sample in high phase, MSB first
            shreg <= {shreg[6:0], sda_s};
            cnt   <= cnt + 4'h1;
          end else if (last_fall) begin
            if (state == T_ADDR) begin
              if (dev_hit) begin
                state          <= T_ACK;
                bus.t_sda_oe_n <= 1'b0;
                is_read        <= shreg[RW_BIT];
                o_comp_sel     <= (shreg[TYPE_HI:TYPE_LO] == DEV_COMP);
              end else begin
                state <= T_IDLE;
              end
            end else if (addr_ok) begin
              state          <= T_ACK;
              bus.t_sda_oe_n <= 1'b0;
            end else begin
              state <= T_IDLE;
            end
          end
        end
        T_ACK: begin
          if (scl_fall) begin
            // Release ack, maybe put first read bit out
            cnt <= 4'h0;
            if (is_read) begin
              state          <= T_TX;
              shreg          <= i_rd_data;
              bus.t_sda_oe_n <= i_rd_data[7];
            end else begin
              state          <= T_RX;
              bus.t_sda_oe_n <= 1'b1;
            end
          end
        end
        T_TX: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (last_fall) begin
            // Let master acknowledge
            state          <= T_MACK;
            bus.t_sda_oe_n <= 1'b1;
          end else if (scl_fall) begin
            shreg          <= {shreg[6:0], 1'b0};
            bus.t_sda_oe_n <= shreg[6];
          end
        end
        T_MACK: begin
          if (scl_rise) begin
            acked <= ~sda_s;
          end else if (scl_fall) begin
            cnt <= 4'h0;
            if (acked) begin
              // Next byte goes out
              state          <= T_TX;
              shreg          <= i_rd_data;
              bus.t_sda_oe_n <= i_rd_data[7];
            end else begin
              state <= T_IDLE;
            end
          end
        end
        default: begin
          state <= T_IDLE;
        end
      endcase
    end
  end

  // Target only pulls low, never the clock
  always_ff @(posedge i_clk_sys) begin
    bus.t_sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Address bytes and address counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      abytes <= 2'h0;
      o_addr <= '0;
    end else if (state == T_ADDR && last_fall && dev_hit && !abort && !start_det) begin
      // Reads use the current address
      abytes <= shreg[RW_BIT] ? 2'h0
              : ((shreg[TYPE_HI:TYPE_LO] == DEV_COMP) ? COMP_ABYTES : MEM_ABYTES);
    end else if (state == T_RX && last_fall && abytes != 2'h0 && addr_ok
                 && !abort && !start_det) begin
      // Address bytes, high byte first
      abytes <= abytes - 2'h1;
      if (o_comp_sel) begin
        o_addr <= {7'h0, shreg};
      end else if (abytes == MEM_ABYTES) begin
        o_addr[ADDR_W-1:8] <= shreg[6:0];
      end else begin
        o_addr[7:0] <= shreg;
      end
    end else if (o_wr_stb) begin
      o_addr <= next_addr(o_addr, o_comp_sel);
    end else if (state == T_TX && last_fall && !abort && !start_det) begin
      // Advance just before acknowledge
      o_addr <= next_addr(o_addr, o_comp_sel);
    end
  end

  // ----------------------------------------------------------------
  // User strobes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_wr_stb  <= 1'b0;
      o_wr_data <= 8'h00;
      o_rd_stb  <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      o_busy   <= (state != T_IDLE);
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (!abort && !start_det) begin
        // Data byte written after eighth bit
        if (state == T_RX && last_fall && abytes == 2'h0) begin
          o_wr_stb  <= 1'b1;
          o_wr_data <= shreg;
        end
        // Read byte fetched at load
        if (scl_fall && ((state == T_ACK && is_read) || (state == T_MACK && acked))) begin
          o_rd_stb <= 1'b1;
        end
      end
    end
  end

endmodule

// [src/dtws_pkg.sv]
// Constants and types shared by both ends of the two-wire link.
// Assumes one 40 MHz system clock on each end.
package dtws_pkg;

  // ----------------------------------------------------------------
  // Address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_MEM       = 4'ha;   // Memory type code
  localparam logic [3:0] DEV_COMP      = 4'hd;   // Companion type code
  localparam int         TYPE_HI       = 7;      // Type field top
  localparam int         TYPE_LO       = 4;      // Type field bottom
  localparam int         SEL_HI        = 2;      // Select field top
  localparam int         SEL_LO        = 1;      // Select field bottom
  localparam int         RW_BIT        = 0;      // Read flag position
  localparam logic [7:0] COMP_ADDR_MAX = 8'h18;  // Highest companion address

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS   = 4'h8;  // Bits per byte
  localparam int         ADDR_W      = 15;    // Memory address width
  localparam logic [1:0] MEM_ABYTES  = 2'h2;  // Memory address bytes
  localparam logic [1:0] COMP_ABYTES = 2'h1;  // Companion address bytes

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;    // System clock period
  localparam int SCL_PERIOD_NS = 1000;  // Serial clock period made by master
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);  // Divider end

  // ----------------------------------------------------------------
  // State and command types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    T_IDLE = 3'h0,  // Waiting for start
    T_ADDR = 3'h1,  // Taking address byte
    T_ACK  = 3'h3,  // Driving acknowledge
    T_RX   = 3'h2,  // Taking address or data
    T_TX   = 3'h6,  // Sending read data
    T_MACK = 3'h7   // Sampling master acknowledge
  } dtws_tstate_t;

  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,  // Waiting for command
    M_START = 2'h1,  // Making start
    M_BITS  = 2'h3,  // Nine clocks of a byte
    M_STOP  = 2'h2   // Making stop
  } dtws_mstate_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,  // Start or repeated start
    CMD_WRITE = 2'h1,  // Send byte, take acknowledge
    CMD_READ  = 2'h2,  // Take byte, send acknowledge
    CMD_STOP  = 2'h3   // Stop condition
  } dtws_cmd_t;

endpackage

// [src/dtws_if.sv]
// Wires between the bus master end and the target end.
// Assumes pull-ups: a released line reads high.
`timescale 1ns/1ps
interface dtws_if;

  // ----------------------------------------------------------------
  // Drivers and resolved lines
  // ----------------------------------------------------------------
  logic m_scl_o;     // Master clock value
  logic m_scl_oe_n;  // Master clock drive, low drives
  logic m_sda_o;     // Master data value
  logic m_sda_oe_n;  // Master data drive, low drives
  logic t_sda_o;     // Target data value
  logic t_sda_oe_n;  // Target data drive, low drives
  logic scl;         // Resolved clock line
  logic sda;         // Resolved data line

  // Wired-and with pull-up
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (t_sda_oe_n | t_sda_o);

  modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport target (output t_sda_o, t_sda_oe_n, input scl, sda);

endinterface

// [src/dtws_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes idle level of every line is high.
`timescale 1ns/1ps
module dtws_sync #(
  parameter int W = 1  // Number of lines
) (
  input  wire logic         i_clk_sys,  // System clock
  input  wire logic         i_srst,     // Synchronous reset
  input  wire logic [W-1:0] i_async,    // Raw pins
  output logic      [W-1:0] o_sync      // Synchronised pins
);

  logic [W-1:0] meta;  // First stage, read only by second

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta   <= '1;
      o_sync <= '1;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// [src/dtws_master.sv]
// Master end: byte-level command engine that makes the serial clock.
// Assumes a user that issues start, bytes and stop in that order.
`timescale 1ns/1ps
module dtws_master
  import dtws_pkg::*;
(
  input  wire logic       i_clk_sys,    // System clock
  input  wire logic       i_srst,       // Synchronous reset
  dtws_if.master          bus,          // Two-wire lines
  input  wire logic       i_cmd_valid,  // Command offered
  input  wire dtws_cmd_t  i_cmd,        // Command code
  input  wire logic [7:0] i_wr_byte,    // Byte to send
  input  wire logic       i_send_ack,   // Acknowledge a read byte
  output logic            o_cmd_ready,  // Idle, takes command
  output logic            o_done,       // Command finished pulse
  output logic      [7:0] o_rd_byte,    // Byte received
  output logic            o_ack_seen    // Acknowledge received
);

  // ----------------------------------------------------------------
  // Quarter-bit divider and data sampling
  // ----------------------------------------------------------------
  logic         sda_s;  // Synchronised data line
  logic [7:0]   qdiv;   // Divider count
  logic         tick;   // Quarter-bit enable
  dtws_mstate_t state;  // Engine state
  logic [1:0]   qtr;    // Quarter within bit
  logic [3:0]   bitn;   // Bit within byte
  logic [8:0]   tx;     // Bits to put out
  logic [8:0]   rx;     // Bits taken

  dtws_sync #(
    .W (1)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (bus.sda),
    .o_sync    (sda_s)
  );

  // Divider for quarter ticks
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || qdiv == QTR_LAST) begin
      qdiv <= 8'h00;
    end else begin
      qdiv <= qdiv + 8'h01;
    end
  end

  assign tick = (qdiv == QTR_LAST);

  // ----------------------------------------------------------------
  // Command engine and line drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state          <= M_IDLE;
      qtr            <= 2'h0;
      bitn           <= 4'h0;
      tx             <= 9'h1ff;
      rx             <= 9'h000;
      o_cmd_ready    <= 1'b1;
      o_done         <= 1'b0;
      o_rd_byte      <= 8'h00;
      o_ack_seen     <= 1'b0;
      bus.m_scl_oe_n <= 1'b1;
      bus.m_sda_oe_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      unique case (state)
        M_IDLE: begin
          if (i_cmd_valid) begin
            o_cmd_ready <= 1'b0;
            qtr         <= 2'h0;
            bitn        <= 4'h0;
            unique case (i_cmd)
              CMD_START: state <= M_START;
              CMD_STOP:  state <= M_STOP;
              CMD_WRITE: begin
                state <= M_BITS;
                tx    <= {i_wr_byte, 1'b1};
              end
              CMD_READ: begin
                state <= M_BITS;
                tx    <= {8'hff, ~i_send_ack};
              end
            endcase
          end
        end
        M_START: begin
          if (tick) begin
            qtr <= qtr + 2'h1;
            unique case (qtr)
              2'h0: bus.m_sda_oe_n <= 1'b1;  // Data high first
              2'h1: bus.m_scl_oe_n <= 1'b1;
              2'h2: bus.m_sda_oe_n <= 1'b0;
              2'h3: begin
                bus.m_scl_oe_n <= 1'b0;
                state          <= M_IDLE;
                o_cmd_ready    <= 1'b1;
                o_done         <= 1'b1;
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            qtr <= qtr + 2'h1;
            unique case (qtr)
              2'h0: bus.m_sda_oe_n <= 1'b0;  // Data low first
              2'h1: bus.m_scl_oe_n <= 1'b1;
              2'h2: bus.m_sda_oe_n <= 1'b1;
              2'h3: begin
                state       <= M_IDLE;
                o_cmd_ready <= 1'b1;
                o_done      <= 1'b1;
              end
            endcase
          end
        end
        M_BITS: begin
          if (tick) begin
            qtr <= qtr + 2'h1;
            unique case (qtr)
              2'h0: begin
                // Change data only while clock low
                bus.m_sda_oe_n <= tx[8];
                tx             <= {tx[7:0], 1'b1};
              end
              2'h1: bus.m_scl_oe_n <= 1'b1;
              2'h2: rx <= {rx[7:0], sda_s};
              2'h3: begin
                bus.m_scl_oe_n <= 1'b0;
                bitn           <= bitn + 4'h1;
                if (bitn == BYTE_BITS) begin
                  state       <= M_IDLE;
                  o_cmd_ready <= 1'b1;
                  o_done      <= 1'b1;
                  o_rd_byte   <= rx[8:1];
                  o_ack_seen  <= ~rx[0];
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Master pulls lines low only
  always_ff @(posedge i_clk_sys) begin
    bus.m_scl_o <= 1'b0;
    bus.m_sda_o <= 1'b0;
  end

endmodule

// [testbench/dtws_props.sv]
// Checker for the two-wire lines between the master and target ends.
// Assumes it sits beside the link interface in the bench top.
`timescale 1ns/1ps
module dtws_props (
  input wire logic i_clk_sys,   // System clock
  input wire logic i_srst,      // Synchronous reset
  input wire logic m_scl_o,     // Master clock value
  input wire logic m_scl_oe_n,  // Master clock drive
  input wire logic m_sda_o,     // Master data value
  input wire logic m_sda_oe_n,  // Master data drive
  input wire logic t_sda_o,     // Target data value
  input wire logic t_sda_oe_n,  // Target data drive
  input wire logic scl,         // Resolved clock
  input wire logic sda          // Resolved data
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  sequence s_start;  // Data falls, clock high
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence s_stop;  // Data rises, clock high
    $rose(sda) && scl && $past(scl);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_target_open_drain: assert property (!t_sda_o)
    else $error("target data value not low");
  a_master_open_drain: assert property (!m_sda_o && !m_scl_o)
    else $error("master line value not low");
  a_target_moves_low: assert property (
    $changed(t_sda_oe_n) |-> !scl && !$past(scl))
    else $error("target data changed near clock high");
  a_clock_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_stop_releases: assert property (s_stop |-> t_sda_oe_n [*8])
    else $error("target drives after stop");
  a_start_releases: assert property (s_start |-> t_sda_oe_n [*8])
    else $error("target drives after start");
  a_ack_stands: assert property (
    $fell(t_sda_oe_n) |-> !t_sda_oe_n [*8])
    else $error("target drive too short");
  a_sender_yields: assert property (
    $fell(t_sda_oe_n) |-> ##[0:15] m_sda_oe_n)
    else $error("master holds data while target drives");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_start: cover property (s_start);
  c_stop: cover property (s_stop);
  c_target_drive: cover property ($fell(t_sda_oe_n));
endmodule

// [testbench/dual_target_two_wire_slave_bench.sv]
// Bench joining master and target ends over one link.
// Assumes a user byte store whose read data follows the address.
`timescale 1ns/1ps
module dual_target_two_wire_slave_bench
  import dtws_pkg::*;
;
  logic        clk = 1'b0;     // System clock
  logic        srst = 1'b1;    // Reset
  logic        cmd_valid = 0;  // Command offered
  dtws_cmd_t   cmd_code = CMD_START;
  logic [7:0]  wr_byte = 0;    // Byte to send
  logic        send_ack = 0;   // Acknowledge choice
  logic        pfail = 0;      // Power trip
  logic        rdy, done, ack_seen, wr_stb, rd_stb, comp, busy;
  logic [7:0]  rd_byte, wr_data, rd_data;
  logic [14:0] addr;           // Target address
  logic [23:0] wq[$];          // Captured writes
  int          err_count = 0;
  int          comparisons = 0;
  int          rd_cnt = 0;     // Read fetch strobes seen
  int          i;
  logic [7:0]  adr[6] = '{8'ha4, 8'ha0, 8'h54, 8'hd4, 8'hd6, 8'ha2};
  logic [5:0]  ackv = 6'b001001; // Expected acks

  always #12.5 clk = ~clk;
  assign rd_data = addr[7:0] ^ {comp, 7'h35};  // Byte store

  dtws_if link ();
  dtws_master u_dtws_master (.i_clk_sys(clk), .i_srst(srst), .bus(link),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd_code), .i_wr_byte(wr_byte),
    .i_send_ack(send_ack), .o_cmd_ready(rdy), .o_done(done),
    .o_rd_byte(rd_byte), .o_ack_seen(ack_seen));
  dtws_target u_dtws_target (.i_clk_sys(clk), .i_srst(srst), .bus(link),
    .i_sel_pins(2'b10), .i_power_fail(pfail), .i_rd_data(rd_data),
    .o_wr_stb(wr_stb), .o_wr_data(wr_data), .o_rd_stb(rd_stb),
    .o_addr(addr), .o_comp_sel(comp), .o_busy(busy));
  dtws_props u_props (.i_clk_sys(clk), .i_srst(srst),
    .m_scl_o(link.m_scl_o), .m_scl_oe_n(link.m_scl_oe_n),
    .m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n),
    .t_sda_o(link.t_sda_o), .t_sda_oe_n(link.t_sda_oe_n),
    .scl(link.scl), .sda(link.sda));

  // Record every write strobe
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back({comp, addr, wr_data});
    end
    if (rd_stb === 1'b1) begin
      rd_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] ex(input logic c, input logic [7:0] a);
    return a ^ {c, 7'h35};  // Expected store byte
  endfunction

  task automatic summarize();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One master command, bounded wait for done
  task automatic cmd(input dtws_cmd_t c, input logic [7:0] b, input logic a);
    int n;
    cmd_valid = 1'b1;
    cmd_code = c;
    wr_byte = b;
    send_ack = a;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    for (n = 0; n < 600 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      chk("done", 1, 0);
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic e);
    cmd(CMD_WRITE, b, 1'b0);
    chk("ack", e, ack_seen);
  endtask

  task automatic rd(input logic [7:0] e, input logic a);
    cmd(CMD_READ, 8'h00, a);
    chk("read", e, rd_byte);
  endtask

  task automatic wchk(input logic [23:0] e);
    if (wq.size() == 0) chk("write", e, 'x);
    else chk("write", e, wq.pop_front());
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    cmd(CMD_START, 0, 0);
    wr(8'ha4, 1);
    wr(8'h81, 1);
    wr(8'h23, 1);
    chk("busy", 1, busy);
    wr(8'h5c, 1);
    wr(8'ha7, 1);
    wchk({1'b0, 15'h0123, 8'h5c});
    wchk({1'b0, 15'h0124, 8'ha7});
    cmd(CMD_STOP, 0, 0);
    chk("idle lines", 2'b11, {link.scl, link.sda});
    chk("busy", 0, busy);
    cmd(CMD_START, 0, 0);
    wr(8'ha5, 1);
    rd(ex(0, 8'h25), 1);
    rd(ex(0, 8'h26), 0);
    repeat (6) @(posedge clk);
    #1;
    chk("released", 1, link.t_sda_oe_n);
    chk("busy", 0, busy);
    cmd(CMD_STOP, 0, 0);
    cmd(CMD_START, 0, 0);
    wr(8'hd4, 1);
    wr(8'h18, 1);
    wr(8'h77, 1);
    wchk({1'b1, 15'h0018, 8'h77});
    cmd(CMD_START, 0, 0);
    wr(8'hd5, 1);
    rd(ex(1, 8'h19), 0);
    chk("reads", 3, rd_cnt);
    cmd(CMD_START, 0, 0);
    wr(8'hd4, 1);
    wr(8'h19, 0);
    for (i = 0; i < 6; i++) begin
      cmd(CMD_START, 0, 0);
      wr(adr[i], ackv[i]);
    end
    cmd(CMD_START, 0, 0);
    wr(8'ha4, 1);
    wr(8'h00, 1);
    wr(8'h40, 1);
    cmd(CMD_START, 0, 0);
    wr(8'ha4, 1);
    pfail = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    pfail = 1'b0;
    chk("busy", 0, busy);
    wr(8'h00, 0);
    cmd(CMD_STOP, 0, 0);
    chk("queue", 0, wq.size());
    chk("ready", 1, rdy);
    summarize();
  end
endmodule
